// [shared/sam_pkg.sv]
// Purpose: constants shared by the scale alarm monitor
// Assumes: 200 MHz pclk, APB with 32-bit data
// Notes: alarm vector bit positions are fixed here for status, mask and link flags
`default_nettype none
package sam_pkg;
    // clock
    localparam int CLK_PERIOD_NS = 5;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_ALARM = 8'h0C;
    localparam logic [7:0] OFS_POSITION = 8'h10;
    localparam logic [7:0] OFS_ZERO = 8'h14;
    localparam logic [7:0] OFS_SIGWIN = 8'h18;
    // ctrl fields
    localparam int CTRL_REINIT_BIT = 0;
    // alarm vector layout: two cautions below six errors
    localparam int AL_SIG_CAUTION = 0;
    localparam int AL_THERMAL = 1;
    localparam int AL_OVERSPEED = 2;
    localparam int AL_INIT = 3;
    localparam int AL_HARDWARE = 4;
    localparam int AL_ABS = 5;
    localparam int AL_COMM = 6;
    localparam int AL_SIG_ERROR = 7;
    localparam int ALARM_W = 8;
    localparam int ALARM_BUSY_BIT = 8;
    // sigwin fields: caution low/high, error low/high, 8 bits each
    localparam int SW_CLO = 0;
    localparam int SW_CHI = 8;
    localparam int SW_ELO = 16;
    localparam int SW_EHI = 24;
    // reset values
    localparam logic [31:0] SIGWIN_RST = 32'hF00A_E020;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [31:0] ZERO_RST = 32'h0000_0000;
    // thermal caution threshold, degrees C
    localparam logic [7:0] THERMAL_LIMIT_C = 8'h41;
    // over-speed: 8 m/s, expressed in mm/s, checked over a 1 us window
    localparam longint OVERSPEED_MM_S = 8000;
    localparam longint SPEED_WIN_NS = 1000;
    localparam int SPEED_WIN_CYC = int'(SPEED_WIN_NS / CLK_PERIOD_NS);
    // initialization run length in cycles
    localparam int INIT_CYC = 64;
    // reinit request code on the link
    localparam logic [7:0] REINIT_CODE = 8'hA5;
    typedef enum logic [0:0] {ST_INIT, ST_RUN} sam_state_type;
endpackage
`default_nettype wire

// [core/sam_monitor.sv]
// Purpose: alarm detection, latching and reporting inside the read head
// Assumes: all sensor and link inputs come from logic on pclk; no resynchronising
// Notes: APB slave answers with no wait states; one level irq from sticky status
//
// Operation
// - with zero mid-range, position grows as the head moves toward its connector.
// - signal-level and heat alarms are cautions, separate from error-class alarms.
// - cautions never latch; they drop by themselves once the cause is gone.
// - errors latch until an explicit error reset or a power cycle.
// - signal caution while level is outside its window; position stays valid.
// - thermal caution while internal temperature exceeds 65 degrees C.
// - latched over-speed error when travel speed reaches or exceeds 8 m/s.
// - latched init error on a fault during the initialization run.
// - latched hardware error when self-diagnosis finds an abnormality.
// - latched absolute error when the absolute tracks do not agree.
// - latched comm error when the internal head-to-connector link fails.
// - latched signal error when level is far enough out to corrupt data.
`timescale 1ns/1ps
`default_nettype none
module sam_monitor #(
    parameter int INIT_CYC = sam_pkg::INIT_CYC,
    parameter int SPEED_WIN_CYC = sam_pkg::SPEED_WIN_CYC,
    parameter int RES_PM = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic signed [31:0] head_count,
    input wire logic [7:0] sig_level,
    input wire logic [7:0] temp_c,
    input wire logic init_fault,
    input wire logic selftest_fail,
    input wire logic track_mismatch,
    input wire logic head_link_fail,
    input wire logic link_cmd_valid,
    input wire logic [7:0] link_cmd_code,
    output logic [31:0] link_position,
    output logic [7:0] link_status
);
    localparam int ICW = $clog2(INIT_CYC + 1);
    localparam int WCW = $clog2(SPEED_WIN_CYC + 1);
    // counts travelled in one window at the speed limit
    localparam longint LIM_L = sam_pkg::OVERSPEED_MM_S * longint'(SPEED_WIN_CYC)
        * longint'(sam_pkg::CLK_PERIOD_NS) / longint'(RES_PM);
    localparam logic [31:0] SPEED_LIMIT = LIM_L[31:0];

    // refuse settings the counters cannot serve
    if (INIT_CYC < 1 || SPEED_WIN_CYC < 2 || RES_PM < 1 || LIM_L > 64'h7FFF_FFFF)
    begin : g_bad_param
        $error("sam_monitor: unsupported parameter values");
    end

    typedef struct packed {
        sam_pkg::sam_state_type st;
        logic [ICW-1:0] init_cnt;
        logic [WCW-1:0] win_cnt;
        logic signed [31:0] last_count;
        logic [1:0] caution;
        logic [5:0] err;
        logic [7:0] alarm_prev;
        logic [7:0] sts;
        logic [7:0] mask;
        logic [31:0] zero;
        logic [31:0] sigwin;
        logic [31:0] pos;
        logic [31:0] rdata;
        logic rerr;
        logic [7:0] link_sts;
    } sam_reg_type;

    sam_reg_type r_q;
    sam_reg_type r_d;

    logic wr_acc;
    logic rd_setup;
    logic reinit;
    logic sig_caut_now;
    logic sig_err_now;
    logic therm_now;
    logic win_end;
    logic [31:0] delta;
    logic [31:0] speed_abs;
    logic over_now;
    logic [7:0] alarm_now;
    logic [7:0] cl_lo;
    logic [7:0] cl_hi;
    logic [7:0] el_lo;
    logic [7:0] el_hi;

    // bus decode; register reads are captured in setup so prdata comes from a flop
    assign wr_acc = psel && penable && pwrite;
    assign rd_setup = psel && !penable;
    assign pready = 1'b1;
    assign prdata = r_q.rdata;
    assign pslverr = r_q.rerr;
    assign irq = |(r_q.sts & r_q.mask);
    assign link_position = r_q.pos;
    assign link_status = r_q.link_sts;

    // condition detectors
    assign cl_lo = r_q.sigwin[sam_pkg::SW_CLO +: 8];
    assign cl_hi = r_q.sigwin[sam_pkg::SW_CHI +: 8];
    assign el_lo = r_q.sigwin[sam_pkg::SW_ELO +: 8];
    assign el_hi = r_q.sigwin[sam_pkg::SW_EHI +: 8];
    assign sig_caut_now = (sig_level < cl_lo) || (sig_level > cl_hi);
    assign sig_err_now = (sig_level < el_lo) || (sig_level > el_hi);
    assign therm_now = temp_c > sam_pkg::THERMAL_LIMIT_C;
    assign win_end = r_q.win_cnt == WCW'(SPEED_WIN_CYC - 1);
    assign delta = 32'(head_count - r_q.last_count);
    assign speed_abs = delta[31] ? 32'(-delta) : delta;
    assign over_now = win_end && (speed_abs >= SPEED_LIMIT);
    // error reset either from the link code or from software
    assign reinit = (link_cmd_valid && link_cmd_code == sam_pkg::REINIT_CODE)
        || (wr_acc && paddr == sam_pkg::OFS_CTRL && pwdata[sam_pkg::CTRL_REINIT_BIT]);
    assign alarm_now = {r_q.err, r_q.caution};

    // next-state logic for the whole block
    always_comb
    begin
        logic [5:0] err_set;
        err_set = '0;
        r_d = r_q;
        // position counts up toward the connector: head_count grows away from it
        r_d.pos = 32'(r_q.zero - head_count);
        // cautions track their cause every cycle and never hold
        r_d.caution[0] = sig_caut_now;
        r_d.caution[1] = therm_now;
        // speed window
        if (win_end)
        begin
            r_d.win_cnt = '0;
            r_d.last_count = head_count;
        end
        else
        begin
            r_d.win_cnt = r_q.win_cnt + WCW'(1);
        end
        // initialization run
        case (r_q.st)
            sam_pkg::ST_INIT:
            begin
                err_set[sam_pkg::AL_INIT - 2] = init_fault;
                // speed reference follows the head during init, so a restart far from 0 is no jump
                r_d.last_count = head_count;
                r_d.win_cnt = '0;
                if (r_q.init_cnt == ICW'(INIT_CYC - 1))
                begin
                    r_d.st = sam_pkg::ST_RUN;
                end
                else
                begin
                    r_d.init_cnt = r_q.init_cnt + ICW'(1);
                end
            end
            sam_pkg::ST_RUN:
            begin
                r_d.init_cnt = '0;
            end
            default:
            begin
                r_d.st = sam_pkg::ST_INIT;
            end
        endcase
        err_set[sam_pkg::AL_OVERSPEED - 2] = over_now;
        err_set[sam_pkg::AL_HARDWARE - 2] = selftest_fail;
        err_set[sam_pkg::AL_ABS - 2] = track_mismatch;
        err_set[sam_pkg::AL_COMM - 2] = head_link_fail;
        err_set[sam_pkg::AL_SIG_ERROR - 2] = sig_err_now;
        // errors latch; reinit clears them, but a cause present now sets again
        if (reinit)
        begin
            r_d.err = err_set;
            r_d.st = sam_pkg::ST_INIT;
            r_d.init_cnt = '0;
        end
        else
        begin
            r_d.err = r_q.err | err_set;
        end
        // each alarm source keeps its own flag toward the host
        r_d.link_sts = alarm_now;
        // sticky interrupt status on each alarm rising edge; set beats clear
        r_d.alarm_prev = alarm_now;
        if (wr_acc && paddr == sam_pkg::OFS_STATUS)
        begin
            r_d.sts = r_q.sts & ~pwdata[7:0];
        end
        r_d.sts = r_d.sts | (alarm_now & ~r_q.alarm_prev);
        // register writes
        if (wr_acc)
        begin
            case (paddr)
                sam_pkg::OFS_MASK: r_d.mask = pwdata[7:0];
                sam_pkg::OFS_ZERO: r_d.zero = pwdata;
                sam_pkg::OFS_SIGWIN: r_d.sigwin = pwdata;
                default: r_d.mask = r_d.mask;
            endcase
        end
        // read data and error answer captured in the setup cycle
        if (rd_setup)
        begin
            r_d.rerr = 1'b0;
            case (paddr)
                sam_pkg::OFS_CTRL: r_d.rdata = '0;
                sam_pkg::OFS_STATUS: r_d.rdata = {24'h00_0000, r_q.sts};
                sam_pkg::OFS_MASK: r_d.rdata = {24'h00_0000, r_q.mask};
                sam_pkg::OFS_ALARM:
                    r_d.rdata = {23'h00_0000, r_q.st == sam_pkg::ST_INIT, alarm_now};
                sam_pkg::OFS_POSITION: r_d.rdata = r_q.pos;
                sam_pkg::OFS_ZERO: r_d.rdata = r_q.zero;
                sam_pkg::OFS_SIGWIN: r_d.rdata = r_q.sigwin;
                default:
                begin
                    r_d.rdata = '0;
                    r_d.rerr = 1'b1;
                end
            endcase
        end
    end

    // state register; power-up enters the initialization run
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            r_q <= '{st: sam_pkg::ST_INIT, init_cnt: '0, win_cnt: '0, last_count: '0,
                caution: '0, err: '0, alarm_prev: '0, sts: '0, mask: sam_pkg::MASK_RST,
                zero: sam_pkg::ZERO_RST, sigwin: sam_pkg::SIGWIN_RST, pos: '0,
                rdata: '0, rerr: 1'b0, link_sts: '0};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_reinit_req;
        reinit;
    endsequence
    sequence s_init_rerun;
        r_q.st == sam_pkg::ST_INIT && r_q.init_cnt == '0;
    endsequence

    a_pos_toward_conn: assert property (
        presetn |=> r_q.pos == 32'($past(r_q.zero) - $past(head_count)))
        else $error("position not zero minus head count");
    a_class_caution_split: assert property (
        r_q.caution == {$past(therm_now), $past(sig_caut_now)} ##0 link_status == $past(alarm_now))
        else $error("caution bits mixed with error bits");
    a_caution_self_clear: assert property (
        (!sig_caut_now && !therm_now)[*2] |-> r_q.caution == 2'b00)
        else $error("caution held after cause removed");
    a_err_hold: assert property (
        (r_q.err != 6'h00 && !reinit) |=> (r_q.err & $past(r_q.err)) == $past(r_q.err))
        else $error("error cleared without reset");
    a_sig_caution: assert property (
        sig_caut_now |=> r_q.caution[0] ##1 (r_q.caution[0] == $past(sig_caut_now)))
        else $error("signal caution does not follow level");
    a_thermal_caution: assert property (
        (temp_c > 8'h41) |=> r_q.caution[1])
        else $error("thermal caution missing above 65 C");
    a_overspeed_err: assert property (
        (win_end && speed_abs >= SPEED_LIMIT) |=> r_q.err[sam_pkg::AL_OVERSPEED - 2])
        else $error("over-speed not latched");
    a_init_err: assert property (
        (r_q.st == sam_pkg::ST_INIT && init_fault) |=> r_q.err[sam_pkg::AL_INIT - 2])
        else $error("init fault not latched");
    a_hw_err: assert property (
        selftest_fail |=> r_q.err[sam_pkg::AL_HARDWARE - 2]
            ##1 ($past(reinit) || r_q.err[sam_pkg::AL_HARDWARE - 2]))
        else $error("hardware error not latched");
    a_abs_err: assert property (
        track_mismatch |=> r_q.err[sam_pkg::AL_ABS - 2])
        else $error("absolute error not latched");
    a_comm_err: assert property (
        head_link_fail |=> r_q.err[sam_pkg::AL_COMM - 2])
        else $error("comm error not latched");
    a_sig_err: assert property (
        sig_err_now |=> r_q.err[sam_pkg::AL_SIG_ERROR - 2])
        else $error("signal error not latched");
    a_reinit_rerun: assert property (
        s_reinit_req |=> s_init_rerun ##0 r_q.err == {$past(sig_err_now),
            $past(head_link_fail), $past(track_mismatch), $past(selftest_fail),
            $past(init_fault) && $past(r_q.st) == sam_pkg::ST_INIT, $past(over_now)})
        else $error("reinit did not clear errors and rerun init");
    a_link_flags: assert property (
        $rose(r_q.err[sam_pkg::AL_COMM - 2]) |=> link_status[sam_pkg::AL_COMM])
        else $error("link status missing an alarm flag");
endmodule
`default_nettype wire

// [dv/sam_host_model.sv]
// Purpose: servo amplifier side of the position link, issues link commands
// Assumes: commands are launched right after a rising pclk edge
// Notes: the code lines never keep a stale value once the command is withdrawn
`timescale 1ns/1ps
`default_nettype none
module sam_host_model (
    input wire logic pclk,
    output logic link_cmd_valid,
    output logic [7:0] link_cmd_code
);
    // quiet link at time zero
    initial
    begin
        link_cmd_valid = 1'b0;
        link_cmd_code = 8'h00;
    end

    // one-cycle command; the code is inverted afterwards so a design that
    // samples it outside the valid cycle sees garbage, not a lucky match
    task automatic send(input logic [7:0] code);
        link_cmd_valid <= 1'b1;
        link_cmd_code <= code;
        @(posedge pclk);
        link_cmd_valid <= 1'b0;
        link_cmd_code <= ~code;
        @(posedge pclk);
    endtask
endmodule
`default_nettype wire

// [dv/tb_top.sv]
// Purpose: self-checking bench for the alarm monitor over APB and the link
// Assumes: short init run (4 cycles) and speed window (10 cycles)
// Notes: each task starts right after a rising edge and ends on one
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [7:0] paddr, sig_level, temp_c, link_status, link_cmd_code, ev;
    logic [31:0] pwdata, prdata, link_position, rd;
    logic signed [31:0] head_count;
    logic init_fault, selftest_fail, track_mismatch, head_link_fail, link_cmd_valid;
    int bad_count, total_checks;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    sam_monitor #(.INIT_CYC(4), .SPEED_WIN_CYC(10)) sam_monitor_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .head_count(head_count),
        .sig_level(sig_level), .temp_c(temp_c), .init_fault(init_fault),
        .selftest_fail(selftest_fail), .track_mismatch(track_mismatch),
        .head_link_fail(head_link_fail), .link_cmd_valid(link_cmd_valid),
        .link_cmd_code(link_cmd_code), .link_position(link_position),
        .link_status(link_status));

    sam_host_model sam_host_model_i (.pclk(pclk), .link_cmd_valid(link_cmd_valid),
        .link_cmd_code(link_cmd_code));

    // verdict and end of run, also reached when a wait runs out
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one APB transfer; a bounded wait for pready guards against a hang
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            bad_count++;
            tally_and_finish();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask

    // main sequence
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, init_fault, selftest_fail} = '0;
        {track_mismatch, head_link_fail} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        head_count = 32'h0000_0000;
        sig_level = 8'h80;
        temp_c = 8'h19;
        bad_count = 0;
        total_checks = 0;
        ev = 8'h00;
        step(2);
        presetn <= 1'b1;
        rchk("init busy", sam_pkg::OFS_ALARM, 32'h0000_0100);
        step(6);
        rchk("alarm idle", sam_pkg::OFS_ALARM, 32'h0000_0000);
        rchk("mask", sam_pkg::OFS_MASK, 32'h0000_0000);
        rchk("zero", sam_pkg::OFS_ZERO, 32'h0000_0000);
        rchk("sigwin", sam_pkg::OFS_SIGWIN, sam_pkg::SIGWIN_RST);
        rchk("unmapped", 8'h1C, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, {31'h0, er});
        apb(1'b1, sam_pkg::OFS_ALARM, 32'h0000_00FF);
        rchk("alarm ro", sam_pkg::OFS_ALARM, 32'h0000_0000);
        $display("test registers done");
        // caution below and above the window, then self-clearing
        sig_level <= 8'h10;
        step(2);
        rchk("sig low", sam_pkg::OFS_ALARM, 32'h0000_0001);
        sig_level <= 8'hE8;
        step(2);
        rchk("sig high", sam_pkg::OFS_ALARM, 32'h0000_0001);
        sig_level <= 8'h80;
        step(2);
        rchk("sig back", sam_pkg::OFS_ALARM, 32'h0000_0000);
        temp_c <= 8'h41;
        step(2);
        rchk("temp 65", sam_pkg::OFS_ALARM, 32'h0000_0000);
        temp_c <= 8'h42;
        step(2);
        rchk("temp 66", sam_pkg::OFS_ALARM, 32'h0000_0002);
        temp_c <= 8'h19;
        step(2);
        rchk("temp back", sam_pkg::OFS_ALARM, 32'h0000_0000);
        $display("test cautions done");
        // position grows as the head moves toward the connector
        apb(1'b1, sam_pkg::OFS_ZERO, 32'h0000_1000);
        head_count <= 32'h0000_0300;
        step(3);
        chk("link pos", 32'h0000_0D00, link_position);
        rchk("pos reg", sam_pkg::OFS_POSITION, 32'h0000_0D00);
        head_count <= 32'h0000_0200;
        step(3);
        chk("link pos", 32'h0000_0E00, link_position);
        $display("test position done");
        // one-cycle error causes must latch
        for (int i = 0; i < 3; i++)
        begin
            selftest_fail <= (i == 0);
            track_mismatch <= (i == 1);
            head_link_fail <= (i == 2);
            step(1);
            {selftest_fail, track_mismatch, head_link_fail} <= 3'b000;
            step(2);
            ev = ev | (8'h10 << i);
            rchk("err latch", sam_pkg::OFS_ALARM, {24'h0, ev});
        end
        sig_level <= 8'h05;
        step(2);
        rchk("sig err", sam_pkg::OFS_ALARM, {24'h0, ev | 8'h81});
        sig_level <= 8'h80;
        step(2);
        ev = ev | 8'h80;
        rchk("sig err held", sam_pkg::OFS_ALARM, {24'h0, ev});
        head_count <= 32'h0100_0000;
        step(25);
        ev = ev | 8'h04;
        rchk("overspeed", sam_pkg::OFS_ALARM, {24'h0, ev});
        chk("link status", {24'h0, ev}, {24'h0, link_status});
        $display("test errors done");
        // sticky status, mask and level interrupt
        rchk("status", sam_pkg::OFS_STATUS, 32'h0000_00F7);
        chk("irq off", 32'h0000_0000, {31'h0, irq});
        apb(1'b1, sam_pkg::OFS_MASK, 32'h0000_0010);
        chk("irq on", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, sam_pkg::OFS_STATUS, 32'h0000_0010);
        rchk("status w1c", sam_pkg::OFS_STATUS, 32'h0000_00E7);
        chk("irq clr", 32'h0000_0000, {31'h0, irq});
        $display("test interrupt done");
        // only the reinit link code or the ctrl reinit bit clears errors; a live init fault re-raises
        sam_host_model_i.send(8'h5A);
        step(2);
        rchk("bad code", sam_pkg::OFS_ALARM, {24'h0, ev});
        init_fault <= 1'b1;
        sam_host_model_i.send(sam_pkg::REINIT_CODE);
        init_fault <= 1'b0;
        step(8);
        rchk("reinit", sam_pkg::OFS_ALARM, 32'h0000_0008);
        chk("link status", 32'h0000_0008, {24'h0, link_status});
        apb(1'b1, sam_pkg::OFS_CTRL, 32'h0000_0001);
        step(8);
        rchk("ctrl reinit", sam_pkg::OFS_ALARM, 32'h0000_0000);
        $display("test reinit done");
        // a power cycle also drops a latched error and reruns initialization
        selftest_fail <= 1'b1;
        step(1);
        selftest_fail <= 1'b0;
        rchk("hw again", sam_pkg::OFS_ALARM, 32'h0000_0010);
        presetn <= 1'b0;
        step(2);
        presetn <= 1'b1;
        rchk("power cycle", sam_pkg::OFS_ALARM, 32'h0000_0100);
        step(20);
        rchk("after init", sam_pkg::OFS_ALARM, 32'h0000_0000);
        chk("link status", 32'h0000_0000, {24'h0, link_status});
        $display("test power cycle done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
